// ===== remote_gate_pkg.sv
// Package for the remote-input command gate: input map, field layout, types
package remote_gate_pkg;

  // ----------------------------------------
  // Default input assignment
  // ----------------------------------------
  localparam int unsigned NUM_INPUTS = 24;
  localparam int unsigned IDX_W = 5;
  localparam logic [IDX_W-1:0] UNASSIGNED = 5'h1f;
  localparam logic [IDX_W-1:0] DEF_START = 5'h00;
  localparam logic [IDX_W-1:0] DEF_SEL1 = 5'h01;
  localparam logic [IDX_W-1:0] DEF_SEL2 = 5'h02;
  localparam logic [IDX_W-1:0] DEF_SEL4 = 5'h03;
  localparam logic [IDX_W-1:0] DEF_STOP = 5'h04;
  localparam logic [IDX_W-1:0] DEF_PAUSE = 5'h05;
  localparam logic [IDX_W-1:0] DEF_CONT = 5'h06;
  localparam logic [IDX_W-1:0] DEF_RESET = 5'h07;
  localparam int unsigned SEL_BITS = 6;
  localparam int unsigned SYNC_STAGES = 2;

  // ----------------------------------------
  // Function slots of the assignment table
  // ----------------------------------------
  localparam int unsigned F_START = 0;
  localparam int unsigned F_SEL1 = 1;
  localparam int unsigned F_SEL2 = 2;
  localparam int unsigned F_SEL4 = 3;
  localparam int unsigned F_SEL8 = 4;
  localparam int unsigned F_SEL16 = 5;
  localparam int unsigned F_SEL32 = 6;
  localparam int unsigned F_STOP = 7;
  localparam int unsigned F_PAUSE = 8;
  localparam int unsigned F_CONT = 9;
  localparam int unsigned F_RESET = 10;
  localparam int unsigned F_LOWPWR = 11;
  localparam int unsigned NUM_FUNCS = 12;

  typedef logic [NUM_FUNCS-1:0][IDX_W-1:0] func_map_t;

  localparam func_map_t DEFAULT_MAP = {UNASSIGNED, DEF_RESET, DEF_CONT, DEF_PAUSE, DEF_STOP,
                                       UNASSIGNED, UNASSIGNED, UNASSIGNED, DEF_SEL4, DEF_SEL2,
                                       DEF_SEL1, DEF_START};

  // Controller status as seen by the gate
  typedef struct packed {
    logic ready;
    logic running;
    logic paused;
    logic error;
    logic emergency_stop_active;
    logic guard_open_active;
  } ctrl_status_t;

  // One-cycle command pulses out of the gate
  typedef struct packed {
    logic start;
    logic stop;
    logic pause;
    logic cont;
    logic reset;
  } cmd_pulse_t;

endpackage : remote_gate_pkg

// ===== input_sync_edge.sv
// Synchroniser and rising-edge detector for a vector of remote inputs
`timescale 1ns/10ps
`default_nettype none
module input_sync_edge #(
  parameter int unsigned WIDTH = 24
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] raw_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] prev_ff;

  // ----------------------------------------
  // Per-bit two-stage sync plus history
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      // First stage feeds only the second
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          meta_ff[gi] <= 1'b0;
          sync_ff[gi] <= 1'b0;
          prev_ff[gi] <= 1'b0;
        end else begin
          meta_ff[gi] <= raw_in[gi];
          sync_ff[gi] <= meta_ff[gi];
          prev_ff[gi] <= sync_ff[gi];
        end
      end
    end
  endgenerate

  // Off-to-on seen on synchronised level
  assign level_out = sync_ff;
  assign rise_out = sync_ff & ~prev_ff;

endmodule : input_sync_edge
`default_nettype wire

// ===== remote_input_command_gate.sv
// Remote-input command gate: decodes remote inputs into accepted command pulses
// Overview of operation
// - Auto mode on when remote enabled
// - Commands fire on accepted rising edge; select bits and low power follow level
// - Error blocks all commands but reset
// - Default map start, select, stop..reset
// - Start needs ready, no faults, inputs
// - Six weighted select bits pick program
// - Stop accepted whenever no error is present
// - Pause only while running
// - Continue when paused, pause/stop off
// - Reset only while ready, clears faults
// - Forced low power accepted any time
// - Auto mode gates the commands; select bits follow inputs anyway
`timescale 1ns/10ps
`default_nettype none
module remote_input_command_gate
#(
  parameter int unsigned N_IN = remote_gate_pkg::NUM_INPUTS
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [N_IN-1:0] remote_in,
  input wire logic remote_assigned,
  input wire logic control_is_remote,
  input wire logic map_load,
  input wire remote_gate_pkg::func_map_t map_in,
  input wire remote_gate_pkg::ctrl_status_t status_in,
  output logic auto_mode_active,
  output remote_gate_pkg::cmd_pulse_t cmd_out,
  output logic [remote_gate_pkg::SEL_BITS-1:0] start_program,
  output logic [remote_gate_pkg::SEL_BITS-1:0] program_select_bits,
  output logic forced_low_power,
  output logic high_power_blocked,
  output logic clear_faults
);
  import remote_gate_pkg::*;

  // ----------------------------------------
  // Input conditioning
  // ----------------------------------------
  logic [N_IN-1:0] lvl;
  logic [N_IN-1:0] rise;

  input_sync_edge #(.WIDTH(N_IN)) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .raw_in(remote_in),
    .level_out(lvl),
    .rise_out(rise)
  );

  // ----------------------------------------
  // Function assignment table
  // ----------------------------------------
  func_map_t map_ff;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      map_ff <= DEFAULT_MAP;
    end else if (map_load) begin
      map_ff <= map_in;
    end
  end

  // Level and edge per function; unassigned slot reads off
  logic [NUM_FUNCS-1:0] f_lvl;
  logic [NUM_FUNCS-1:0] f_rise;
  genvar gf;
  generate
    for (gf = 0; gf < NUM_FUNCS; gf++) begin : g_func
      wire in_range = (32'(map_ff[gf]) < N_IN);
      assign f_lvl[gf] = in_range ? lvl[map_ff[gf]] : 1'b0;
      assign f_rise[gf] = in_range ? rise[map_ff[gf]] : 1'b0;
    end
  endgenerate

  // ----------------------------------------
  // Acceptance conditions
  // ----------------------------------------
  // remote enabled drives auto mode
  wire auto_ok = remote_assigned & control_is_remote;
  wire no_err = ~status_in.error;
  wire start_ok = status_in.ready & no_err & ~status_in.emergency_stop_active &
                  ~status_in.guard_open_active & ~f_lvl[F_PAUSE] & ~f_lvl[F_STOP];
  wire pause_ok = status_in.running & no_err;
  wire cont_ok = status_in.paused & ~f_lvl[F_PAUSE] & ~f_lvl[F_STOP] & no_err;
  wire reset_ok = status_in.ready;
  wire stop_ok = no_err;

  // edge, condition and auto mode together
  wire acc_start = auto_ok & f_rise[F_START] & start_ok;
  wire acc_stop = auto_ok & f_rise[F_STOP] & stop_ok;
  wire acc_pause = auto_ok & f_rise[F_PAUSE] & pause_ok;
  wire acc_cont = auto_ok & f_rise[F_CONT] & cont_ok;
  wire acc_reset = auto_ok & f_rise[F_RESET] & reset_ok;

  wire [SEL_BITS-1:0] sel_now = {f_lvl[F_SEL32], f_lvl[F_SEL16], f_lvl[F_SEL8],
                                 f_lvl[F_SEL4], f_lvl[F_SEL2], f_lvl[F_SEL1]};

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  cmd_pulse_t cmd_ff;
  logic [SEL_BITS-1:0] prog_ff;
  logic [SEL_BITS-1:0] sel_ff;
  logic auto_ff;
  logic lowpwr_ff;

  // Registered so pulses are glitch free; one cycle latency
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_ff <= '0;
      prog_ff <= '0;
      sel_ff <= '0;
      auto_ff <= 1'b0;
      lowpwr_ff <= 1'b0;
    end else begin
      cmd_ff <= '{start: acc_start, stop: acc_stop, pause: acc_pause, cont: acc_cont, reset: acc_reset};
      sel_ff <= sel_now;
      auto_ff <= auto_ok;
      lowpwr_ff <= f_lvl[F_LOWPWR];
      if (acc_start) begin
        prog_ff <= sel_now;
      end
    end
  end

  assign cmd_out = cmd_ff;
  assign start_program = prog_ff;
  assign program_select_bits = sel_ff;
  assign auto_mode_active = auto_ff;
  assign forced_low_power = lowpwr_ff;
  assign high_power_blocked = lowpwr_ff;
  assign clear_faults = cmd_ff.reset;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_auto_follow;
    @(posedge ref_clk) disable iff (!nrst) 1'b1 ##1 (auto_mode_active == $past(auto_ok));
  endproperty
  a_auto_follow: assert property (p_auto_follow) else $error("auto mode not following enable");

  property p_no_cmd_without_auto;
    @(posedge ref_clk) disable iff (!nrst) !auto_ok |=> (cmd_out == '0);
  endproperty
  a_no_cmd_without_auto: assert property (p_no_cmd_without_auto) else $error("command without auto mode");

  property p_err_blocks;
    @(posedge ref_clk) disable iff (!nrst)
      status_in.error |=> !(cmd_out.start | cmd_out.stop | cmd_out.pause | cmd_out.cont);
  endproperty
  a_err_blocks: assert property (p_err_blocks) else $error("command passed during error");

  property p_start_cond;
    @(posedge ref_clk) disable iff (!nrst)
      (f_rise[F_START] && auto_ok && start_ok) |=> cmd_out.start && (start_program == $past(sel_now));
  endproperty
  a_start_cond: assert property (p_start_cond) else $error("accepted start not issued");

  property p_start_block;
    @(posedge ref_clk) disable iff (!nrst) (!status_in.ready || f_lvl[F_STOP]) |=> !cmd_out.start;
  endproperty
  a_start_block: assert property (p_start_block) else $error("start issued when refused");

  property p_pause_run;
    @(posedge ref_clk) disable iff (!nrst) !status_in.running |=> !cmd_out.pause;
  endproperty
  a_pause_run: assert property (p_pause_run) else $error("pause without running");

  property p_cont_cond;
    @(posedge ref_clk) disable iff (!nrst) (!status_in.paused || f_lvl[F_PAUSE]) |=> !cmd_out.cont;
  endproperty
  a_cont_cond: assert property (p_cont_cond) else $error("continue issued when refused");

  property p_reset_ready;
    @(posedge ref_clk) disable iff (!nrst) cmd_out.reset |-> $past(status_in.ready) && clear_faults;
  endproperty
  a_reset_ready: assert property (p_reset_ready) else $error("reset without ready");

  property p_stop_pulse;
    @(posedge ref_clk) disable iff (!nrst) cmd_out.stop |=> !cmd_out.stop;
  endproperty
  a_stop_pulse: assert property (p_stop_pulse) else $error("stop pulse longer than one cycle");

  property p_lowpwr;
    @(posedge ref_clk) disable iff (!nrst) 1'b1 ##1 (forced_low_power == $past(f_lvl[F_LOWPWR]));
  endproperty
  a_lowpwr: assert property (p_lowpwr) else $error("low power not following input");

  property p_stop_accept;
    @(posedge ref_clk) disable iff (!nrst) (auto_ok && f_rise[F_STOP] && !status_in.error) |=> cmd_out.stop;
  endproperty
  a_stop_accept: assert property (p_stop_accept) else $error("accepted stop not issued");

  property p_start_faults;
    @(posedge ref_clk) disable iff (!nrst)
      (status_in.emergency_stop_active || status_in.guard_open_active || f_lvl[F_PAUSE]) |=> !cmd_out.start;
  endproperty
  a_start_faults: assert property (p_start_faults) else $error("start issued with fault or pause");

  property p_cont_stop;
    @(posedge ref_clk) disable iff (!nrst) f_lvl[F_STOP] |=> !cmd_out.cont;
  endproperty
  a_cont_stop: assert property (p_cont_stop) else $error("continue issued with stop held");

  property p_sel_follow;
    @(posedge ref_clk) disable iff (!nrst) 1'b1 ##1 (program_select_bits == $past(sel_now));
  endproperty
  a_sel_follow: assert property (p_sel_follow) else $error("select bits not following inputs");

  c_start: cover property (@(posedge ref_clk) disable iff (!nrst) cmd_out.start);
  c_pause_cont: cover property (@(posedge ref_clk) disable iff (!nrst) cmd_out.pause ##[1:50] cmd_out.cont);
  c_reset_err: cover property (@(posedge ref_clk) disable iff (!nrst) status_in.error && acc_reset);
  c_lowpwr_noauto: cover property (@(posedge ref_clk) disable iff (!nrst) forced_low_power && !auto_mode_active);
  c_stop: cover property (@(posedge ref_clk) disable iff (!nrst) cmd_out.stop);

endmodule : remote_input_command_gate
`default_nettype wire

// ===== remote_sequencer_model.sv
// Far-side sequencer model that drives the remote input lines
`timescale 1ns/10ps
`default_nettype none
module remote_sequencer_model #(
  parameter int unsigned W = 24
) (
  input wire logic ref_clk,
  output logic [W-1:0] remote_in
);
  // ----------------------------------------
  // Line drive
  // ----------------------------------------
  // Lines idle off, like an unpowered output stage
  initial remote_in = '0;

  // Changes land just after a falling edge, never on the sampling edge
  task automatic hold_lines(input logic [W-1:0] mask);
    @(negedge ref_clk);
    remote_in = mask;
  endtask : hold_lines
endmodule : remote_sequencer_model
`default_nettype wire

// ===== remote_input_command_gate_tb.sv
// Self-checking testbench for the remote-input command gate
`timescale 1ns/10ps
`default_nettype none
module remote_input_command_gate_tb;
  import remote_gate_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic remote_assigned = 1'b0;
  logic control_is_remote = 1'b0;
  logic map_load = 1'b0;
  func_map_t map_in = DEFAULT_MAP;
  ctrl_status_t status_in = '0;
  wire logic [NUM_INPUTS-1:0] remote_in;
  logic auto_mode_active;
  logic forced_low_power;
  logic high_power_blocked;
  logic clear_faults;
  cmd_pulse_t cmd_out;
  logic [SEL_BITS-1:0] start_program;
  logic [SEL_BITS-1:0] program_select_bits;
  logic clr = 1'b1;
  logic [4:0] seen;
  logic seen_clr;
  logic [23:0] pulses;
  int error_cnt = 0;
  int n_tests = 0;
  int cycles = 0;

  remote_sequencer_model #(.W(NUM_INPUTS)) seq (.ref_clk(ref_clk), .remote_in(remote_in));

  remote_input_command_gate dut (.ref_clk(ref_clk), .nrst(nrst), .remote_in(remote_in),
    .remote_assigned(remote_assigned), .control_is_remote(control_is_remote), .map_load(map_load),
    .map_in(map_in), .status_in(status_in), .auto_mode_active(auto_mode_active), .cmd_out(cmd_out),
    .start_program(start_program), .program_select_bits(program_select_bits),
    .forced_low_power(forced_low_power), .high_power_blocked(high_power_blocked),
    .clear_faults(clear_faults));

  // ----------------------------------------
  // Clock, pulse capture, hang guard
  // ----------------------------------------
  always #5 ref_clk = ~ref_clk;

  // Pulses are one cycle wide, so collect them rather than sample once
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (clr) begin
      seen <= '0;
      seen_clr <= 1'b0;
      pulses <= '0;
    end else begin
      seen <= seen | cmd_out;
      seen_clr <= seen_clr | clear_faults;
      pulses <= pulses + 24'(cmd_out != '0);
    end
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // Hold some lines, set status, then press one line and watch the outcome
  task automatic run(input int idx, input logic [23:0] held, input logic [5:0] st, input logic [4:0] exp);
    logic [23:0] lv;
    lv = held | (24'h1 << idx);
    seq.hold_lines(held);
    status_in = ctrl_status_t'(st);
    repeat (6) @(negedge ref_clk);
    clr = 1'b0;
    seq.hold_lines(lv);
    repeat (12) @(negedge ref_clk);
    check("cmd_out", 24'(seen), 24'(exp));
    check("pulse count", pulses, 24'(exp != '0));
    check("clear_faults", 24'(seen_clr), 24'(exp[0]));
    check("select", 24'(program_select_bits), {18'h0, 2'h0, lv[9], lv[3:1]});
    seq.hold_lines('0);
    clr = 1'b1;
    repeat (6) @(negedge ref_clk);
  endtask : run

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(negedge ref_clk);
    nrst = 1'b1;
    @(negedge ref_clk);
    map_in[F_LOWPWR] = 5'h08;
    map_in[F_SEL8] = 5'h09;
    map_load = 1'b1;
    @(negedge ref_clk);
    map_load = 1'b0;
    check("auto off", 24'(auto_mode_active), 24'h0);
    run(0, 24'h0, 6'h20, 5'h00);
    // Low power works without auto mode
    seq.hold_lines(24'h100);
    repeat (6) @(negedge ref_clk);
    check("low power", 24'(forced_low_power), 24'h1);
    check("hp block", 24'(high_power_blocked), 24'h1);
    seq.hold_lines('0);
    repeat (6) @(negedge ref_clk);
    check("low power off", 24'(forced_low_power), 24'h0);
    remote_assigned = 1'b1;
    control_is_remote = 1'b1;
    repeat (3) @(negedge ref_clk);
    check("auto on", 24'(auto_mode_active), 24'h1);
    run(1, 24'h0, 6'h20, 5'h00);
    run(0, 24'h20e, 6'h20, 5'h10);
    check("start_program", 24'(start_program), 24'h0f);
    run(0, 24'h0, 6'h21, 5'h00);
    run(0, 24'h0, 6'h22, 5'h00);
    run(0, 24'h0, 6'h24, 5'h00);
    run(0, 24'h0, 6'h00, 5'h00);
    run(0, 24'h20, 6'h20, 5'h00);
    run(0, 24'h10, 6'h20, 5'h00);
    run(5, 24'h0, 6'h00, 5'h00);
    run(5, 24'h0, 6'h10, 5'h04);
    run(6, 24'h0, 6'h08, 5'h02);
    run(6, 24'h20, 6'h08, 5'h00);
    run(6, 24'h10, 6'h08, 5'h00);
    run(6, 24'h0, 6'h00, 5'h00);
    run(4, 24'h0, 6'h00, 5'h08);
    run(4, 24'h0, 6'h24, 5'h00);
    run(7, 24'h0, 6'h04, 5'h00);
    // Last case: the sequencer clears the error with reset while ready is set
    run(7, 24'h0, 6'h24, 5'h01);
    conclude();
  end
endmodule : remote_input_command_gate_tb
`default_nettype wire
